//--- line_drv_defines.vh
// Behaviour
// - output enable low tri-states both line outputs
// - power-down disables driver whatever enable says
// - powered-down transmitter: outputs tri-stated, drivers off
// - hardware mode: one pin; processor mode: per-port bits
// - tx termination select bit switches internal termination
// - internal termination only in processor mode
// - rx termination select bit switches internal termination
// - four-bit field sets rx termination value
// - 32 out-of-range reference cycles set amplitude fault
// - amplitude fault interrupts only when enabled
// - monitor idle while transmitter disabled
// - persistence counted on reference clock edges
// - open or shorted line pin sets failure alarm
// - any failure alarm change interrupts when enabled
// - alarm clears only with activity on both pins
// - transmit data passes to line unaltered
`ifndef LINE_DRV_DEFINES_VH
`define LINE_DRV_DEFINES_VH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define ADDR_W 5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFF_CTRL 5'h00
`define OFF_TERM 5'h04
`define OFF_ADJ 5'h08
`define OFF_STATUS 5'h0C
`define OFF_IRQ_EN 5'h10

// ----------------------------------------
// register select codes
// ----------------------------------------
`define SEL_NONE 3'h0
`define SEL_CTRL 3'h1
`define SEL_TERM 3'h2
`define SEL_ADJ 3'h3
`define SEL_STATUS 3'h4
`define SEL_IRQ_EN 3'h5

// ----------------------------------------
// field positions (one byte lane per group)
// ----------------------------------------
`define LANE_LO 0
`define LANE_MID 8
`define LANE_HI 16
`define ADJ_BITS 4
`define MAX_PORTS 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_OE 8'h00
`define RST_PD 8'h00
`define RST_TERM 8'h00
`define RST_ADJ 32'h00000000

// ----------------------------------------
// driver monitor persistence, reference cycles
// ----------------------------------------
`define AMP_PERSIST 32

`endif

//--- drv_amp_monitor.v
`timescale 1ns/1ps
`include "line_drv_defines.vh"

// persistence counter of one port's transmit amplitude monitor
module drv_amp_monitor #(
  parameter PERSIST = `AMP_PERSIST,
  parameter CW = 6
) (
  input wire core_clk,
  input wire rst,
  input wire enable,
  input wire ref_tick,
  input wire out_of_range,
  output reg fault_pulse
);

  // --------------------------------------
  // counter
  // --------------------------------------
  localparam [CW-1:0] LIMIT = PERSIST[CW-1:0];

  reg [CW-1:0] run_count; // consecutive out-of-range reference cycles
  reg fired; // fault already reported for this run

  // count on reference edges only, restart when in range or disabled
  always @(posedge core_clk) begin
    if (rst) begin
      run_count <= {CW{1'b0}};
      fired <= 1'b0;
      fault_pulse <= 1'b0;
    end else begin
      fault_pulse <= 1'b0;
      if (!enable || !out_of_range) begin
        run_count <= {CW{1'b0}};
        fired <= 1'b0;
      end else if (ref_tick && !fired) begin
        if (run_count == LIMIT - 1'b1) begin
          fault_pulse <= 1'b1;
          fired <= 1'b1;
          run_count <= {CW{1'b0}};
        end else begin
          run_count <= run_count + 1'b1;
        end
      end
    end
  end

endmodule

//--- line_driver_ctrl_monitor.v
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "line_drv_defines.vh"

// per-port line driver control, termination and supervision
module line_driver_ctrl_monitor #(
  parameter N_PORTS = 4
) (
  input wire core_clk,
  input wire rst,
  // axi4-lite slave
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // mode and hardware-mode pins
  input wire proc_mode,
  input wire hw_tx_output_enable,
  input wire hw_tx_power_down,
  input wire ref_clk_in,
  // analog status per port
  input wire [N_PORTS-1:0] amp_below_low,
  input wire [N_PORTS-1:0] amp_above_high,
  input wire [N_PORTS-1:0] line_out_pos_fault,
  input wire [N_PORTS-1:0] line_in_pos_fault,
  input wire [N_PORTS-1:0] line_out_pos_activity,
  input wire [N_PORTS-1:0] line_in_pos_activity,
  // transmit data from the encoder, same clock
  input wire [N_PORTS-1:0] tx_pos_data,
  input wire [N_PORTS-1:0] tx_neg_data,
  // line pins and analog controls
  output reg [N_PORTS-1:0] line_out_pos,
  output reg [N_PORTS-1:0] line_out_pos_oe,
  output reg [N_PORTS-1:0] line_out_neg,
  output reg [N_PORTS-1:0] line_out_neg_oe,
  output reg [N_PORTS-1:0] tx_driver_power_on,
  output reg [N_PORTS-1:0] tx_internal_term_on,
  output reg [N_PORTS-1:0] rx_internal_term_on,
  output reg [`ADJ_BITS*N_PORTS-1:0] rx_term_value_adj_out,
  output reg irq
);

  // --------------------------------------
  // constants and helpers
  // --------------------------------------
  localparam N = N_PORTS;
  localparam SW = 4 + 6 * N; // width of the synchronised pin bundle
  localparam [7:0] PMASK = (N >= `MAX_PORTS) ? 8'hFF : ((8'h01 << N) - 8'h01);
  localparam [31:0] ADJ_MASK = (N >= `MAX_PORTS) ? 32'hFFFFFFFF :
                               ((32'h00000001 << (`ADJ_BITS * N)) - 32'h00000001);

  // byte-lane merge under write strobes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[8*i +: 8] = nw[8*i +: 8];
        end
      end
    end
  endfunction

  // address decode shared by read and write
  function [2:0] reg_sel;
    input [`ADDR_W-1:0] a;
    begin
      case (a)
        `OFF_CTRL: reg_sel = `SEL_CTRL;
        `OFF_TERM: reg_sel = `SEL_TERM;
        `OFF_ADJ: reg_sel = `SEL_ADJ;
        `OFF_STATUS: reg_sel = `SEL_STATUS;
        `OFF_IRQ_EN: reg_sel = `SEL_IRQ_EN;
        default: reg_sel = `SEL_NONE;
      endcase
    end
  endfunction

  // --------------------------------------
  // pin synchronisers
  // --------------------------------------
  wire [SW-1:0] pin_raw; // asynchronous pins bundled
  reg [SW-1:0] pin_meta; // first stage, read only by second
  reg [SW-1:0] pin_sync; // second stage, safe to use

  assign pin_raw = {proc_mode, hw_tx_output_enable, hw_tx_power_down, ref_clk_in,
                    amp_below_low, amp_above_high, line_out_pos_fault,
                    line_in_pos_fault, line_out_pos_activity, line_in_pos_activity};

  // two flip-flops on every pin
  always @(posedge core_clk) begin
    if (rst) begin
      pin_meta <= {SW{1'b0}};
      pin_sync <= {SW{1'b0}};
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire mode_proc = pin_sync[SW-1]; // processor interface active
  wire hw_oe_s = pin_sync[SW-2];
  wire hw_pd_s = pin_sync[SW-3];
  wire ref_s = pin_sync[SW-4];
  wire [N-1:0] below_s = pin_sync[6*N-1 -: N];
  wire [N-1:0] above_s = pin_sync[5*N-1 -: N];
  wire [N-1:0] txf_s = pin_sync[4*N-1 -: N];
  wire [N-1:0] rxf_s = pin_sync[3*N-1 -: N];
  wire [N-1:0] txa_s = pin_sync[2*N-1 -: N];
  wire [N-1:0] rxa_s = pin_sync[N-1 -: N];

  // --------------------------------------
  // reference clock edge detect
  // --------------------------------------
  reg ref_d; // previous synchronised reference level
  wire ref_tick = ref_s & ~ref_d;

  always @(posedge core_clk) begin
    if (rst) begin
      ref_d <= 1'b0;
    end else begin
      ref_d <= ref_s;
    end
  end

  // --------------------------------------
  // software registers
  // --------------------------------------
  reg [7:0] oe_bits; // per-port output enable
  reg [7:0] pd_bits; // per-port power-down
  reg [7:0] tx_term_bits; // per-port tx termination select
  reg [7:0] rx_term_bits; // per-port rx termination select
  reg [31:0] adj_bits; // rx termination value, four bits a port
  reg [7:0] amp_sticky; // amplitude fault events
  reg [7:0] fail_sticky; // failure alarm change events
  reg [7:0] amp_irq_en; // driver_amp_fault_irq_en per port
  reg [7:0] fail_irq_en; // tx_fail_alarm_irq_en per port
  reg [N-1:0] tx_fail_alarm; // live failure alarm per port

  // --------------------------------------
  // driver enable per port
  // --------------------------------------
  wire [N-1:0] oe_ctl = mode_proc ? oe_bits[N-1:0] : {N{hw_oe_s}};
  wire [N-1:0] pd_ctl = mode_proc ? pd_bits[N-1:0] : {N{hw_pd_s}};
  wire [N-1:0] drv_on = oe_ctl & ~pd_ctl;

  // --------------------------------------
  // driver amplitude monitors
  // --------------------------------------
  wire [N-1:0] amp_fault; // one-cycle pulse per port

  genvar gp;
  generate
    for (gp = 0; gp < N; gp = gp + 1) begin : g_mon
      drv_amp_monitor #(
        .PERSIST(`AMP_PERSIST),
        .CW(6)
      ) u_mon (
        .core_clk(core_clk),
        .rst(rst),
        .enable(drv_on[gp]),
        .ref_tick(ref_tick),
        .out_of_range(below_s[gp] | above_s[gp]),
        .fault_pulse(amp_fault[gp])
      );
    end
  endgenerate

  // --------------------------------------
  // transmit failure alarm
  // --------------------------------------
  wire [N-1:0] pin_fault = txf_s | rxf_s;
  wire [N-1:0] both_active = txa_s & rxa_s;
  wire [N-1:0] next_fail = pin_fault | (tx_fail_alarm & ~both_active);
  wire [N-1:0] fail_change = next_fail ^ tx_fail_alarm;

  always @(posedge core_clk) begin
    if (rst) begin
      tx_fail_alarm <= {N{1'b0}};
    end else begin
      tx_fail_alarm <= next_fail;
    end
  end

  // --------------------------------------
  // axi write channel
  // --------------------------------------
  reg aw_got; // address held
  reg w_got; // data held
  reg [`ADDR_W-1:0] aw_addr; // held write address
  reg [31:0] w_data; // held write data
  reg [3:0] w_strb; // held strobes
  wire do_write = aw_got & w_got & ~s_axi_bvalid;
  wire [2:0] wsel = reg_sel(aw_addr);
  wire [31:0] wclr = merge(32'h00000000, w_data, w_strb); // ones to clear

  // take address and data in either order, answer after both
  always @(posedge core_clk) begin
    if (rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= {`ADDR_W{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // --------------------------------------
  // register updates
  // --------------------------------------
  wire [2*N+15:0] set_pad = {8'h00, fail_change, 8'h00, amp_fault}; // events zero-padded to byte lanes
  wire [7:0] amp_set = set_pad[`LANE_LO +: 8];
  wire [7:0] fail_set = set_pad[N+`LANE_MID +: 8];
  wire [31:0] ctrl_new = merge({16'h0000, pd_bits, oe_bits}, w_data, w_strb); // control word after write
  wire [31:0] term_new = merge({16'h0000, rx_term_bits, tx_term_bits}, w_data, w_strb); // termination after write
  wire [31:0] irq_en_new = merge({16'h0000, fail_irq_en, amp_irq_en}, w_data, w_strb); // enables after write
  wire [7:0] amp_clr = (do_write && wsel == `SEL_STATUS) ? wclr[`LANE_LO +: 8] : 8'h00;
  wire [7:0] fail_clr = (do_write && wsel == `SEL_STATUS) ? wclr[`LANE_MID +: 8] : 8'h00;

  // writes store masked fields; status bits clear on one, set wins
  always @(posedge core_clk) begin
    if (rst) begin
      oe_bits <= `RST_OE;
      pd_bits <= `RST_PD;
      tx_term_bits <= `RST_TERM;
      rx_term_bits <= `RST_TERM;
      adj_bits <= `RST_ADJ;
      amp_irq_en <= 8'h00;
      fail_irq_en <= 8'h00;
      amp_sticky <= 8'h00;
      fail_sticky <= 8'h00;
    end else begin
      amp_sticky <= (amp_sticky & ~amp_clr) | amp_set;
      fail_sticky <= (fail_sticky & ~fail_clr) | fail_set;
      if (do_write) begin
        case (wsel)
          `SEL_CTRL: begin
            oe_bits <= ctrl_new[`LANE_LO +: 8] & PMASK;
            pd_bits <= ctrl_new[`LANE_MID +: 8] & PMASK;
          end
          `SEL_TERM: begin
            tx_term_bits <= term_new[`LANE_LO +: 8] & PMASK;
            rx_term_bits <= term_new[`LANE_MID +: 8] & PMASK;
          end
          `SEL_ADJ: begin
            adj_bits <= merge(adj_bits, w_data, w_strb) & ADJ_MASK;
          end
          `SEL_IRQ_EN: begin
            amp_irq_en <= irq_en_new[`LANE_LO +: 8] & PMASK;
            fail_irq_en <= irq_en_new[`LANE_MID +: 8] & PMASK;
          end
          default: oe_bits <= oe_bits;
        endcase
      end
    end
  end

  // --------------------------------------
  // axi read channel
  // --------------------------------------
  reg [31:0] rd_mux; // word selected by the read address
  reg [7:0] alarm_byte; // live alarm padded to a byte

  always @* begin
    alarm_byte = 8'h00;
    alarm_byte[N-1:0] = tx_fail_alarm;
    case (reg_sel(s_axi_araddr))
      `SEL_CTRL: rd_mux = {16'h0000, pd_bits, oe_bits};
      `SEL_TERM: rd_mux = {16'h0000, rx_term_bits, tx_term_bits};
      `SEL_ADJ: rd_mux = adj_bits;
      `SEL_STATUS: rd_mux = {8'h00, alarm_byte, fail_sticky, amp_sticky};
      `SEL_IRQ_EN: rd_mux = {16'h0000, fail_irq_en, amp_irq_en};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // one read at a time, data registered at acceptance
  always @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= (reg_sel(s_axi_araddr) == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // --------------------------------------
  // line pins, analog controls, interrupt
  // --------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      line_out_pos <= {N{1'b0}};
      line_out_neg <= {N{1'b0}};
      line_out_pos_oe <= {N{1'b0}};
      line_out_neg_oe <= {N{1'b0}};
      tx_driver_power_on <= {N{1'b0}};
      tx_internal_term_on <= {N{1'b0}};
      rx_internal_term_on <= {N{1'b0}};
      rx_term_value_adj_out <= {(`ADJ_BITS*N){1'b0}};
      irq <= 1'b0;
    end else begin
      line_out_pos_oe <= drv_on;
      line_out_neg_oe <= drv_on;
      line_out_pos <= tx_pos_data & drv_on;
      line_out_neg <= tx_neg_data & drv_on;
      tx_driver_power_on <= ~pd_ctl;
      tx_internal_term_on <= mode_proc ? tx_term_bits[N-1:0] : {N{1'b0}};
      rx_internal_term_on <= mode_proc ? rx_term_bits[N-1:0] : {N{1'b0}};
      rx_term_value_adj_out <= mode_proc ? adj_bits[`ADJ_BITS*N-1:0] :
                               {(`ADJ_BITS*N){1'b0}};
      irq <= |(amp_sticky & amp_irq_en) | |(fail_sticky & fail_irq_en);
    end
  end

endmodule

//--- line_drv_properties.sv
`timescale 1ns/1ps
`include "line_drv_defines.vh"

// ----------------------------------------
// port checks of the line driver block
// ----------------------------------------
module line_drv_props #(
  parameter N_PORTS = 4
) (
  input wire core_clk,
  input wire rst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire proc_mode,
  input wire hw_tx_output_enable,
  input wire hw_tx_power_down,
  input wire [N_PORTS-1:0] tx_pos_data,
  input wire [N_PORTS-1:0] tx_neg_data,
  input wire [N_PORTS-1:0] line_out_pos,
  input wire [N_PORTS-1:0] line_out_pos_oe,
  input wire [N_PORTS-1:0] line_out_neg,
  input wire [N_PORTS-1:0] line_out_neg_oe,
  input wire [N_PORTS-1:0] tx_driver_power_on,
  input wire [N_PORTS-1:0] tx_internal_term_on,
  input wire [N_PORTS-1:0] rx_internal_term_on,
  input wire [`ADJ_BITS*N_PORTS-1:0] rx_term_value_adj_out
);
  // one clock domain for every check
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_oe_pair_same: assert property (line_out_pos_oe == line_out_neg_oe)
    else $error("line output enables differ");
  a_oe_needs_power: assert property ((line_out_pos_oe & ~tx_driver_power_on) == 0)
    else $error("line driven while powered down");
  a_hw_pins_off: assert property ((!proc_mode && (hw_tx_power_down || !hw_tx_output_enable)) [*5]
    |-> line_out_pos_oe == 0 && line_out_neg_oe == 0) else $error("pin disable ignored");
  a_hw_no_term: assert property (!proc_mode [*4] |-> tx_internal_term_on == 0
    && rx_internal_term_on == 0 && rx_term_value_adj_out == 0) else $error("termination in pin mode");
  a_data_pass: assert property (((line_out_pos ^ $past(tx_pos_data)) & line_out_pos_oe) == 0
    && ((line_out_neg ^ $past(tx_neg_data)) & line_out_neg_oe) == 0) else $error("line data altered");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
endmodule

bind line_driver_ctrl_monitor line_drv_props #(.N_PORTS(N_PORTS)) i_props (.core_clk, .rst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .proc_mode, .hw_tx_output_enable, .hw_tx_power_down, .tx_pos_data, .tx_neg_data, .line_out_pos,
  .line_out_pos_oe, .line_out_neg, .line_out_neg_oe, .tx_driver_power_on, .tx_internal_term_on,
  .rx_internal_term_on, .rx_term_value_adj_out);

//--- coax_line_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// coaxial line and transformer at the pins
// ----------------------------------------
module coax_line_model #(
  parameter N_PORTS = 4,
  parameter REF_HALF = 32
) (
  input wire [N_PORTS-1:0] line_out_pos_oe,
  input wire [N_PORTS-1:0] tx_short,
  input wire [N_PORTS-1:0] tx_open,
  input wire [N_PORTS-1:0] rx_open,
  output logic ref_clk_in,
  output wire [N_PORTS-1:0] amp_below_low,
  output wire [N_PORTS-1:0] amp_above_high,
  output wire [N_PORTS-1:0] line_out_pos_fault,
  output wire [N_PORTS-1:0] line_in_pos_fault,
  output wire [N_PORTS-1:0] line_out_pos_activity,
  output wire [N_PORTS-1:0] line_in_pos_activity
);
  // free-running reference, slower than a quarter of core_clk
  initial ref_clk_in = 1'h0;
  always #(REF_HALF) ref_clk_in = ~ref_clk_in;
  // undriven or shorted line has too little swing
  assign amp_below_low = ~line_out_pos_oe | tx_short;
  // near open reflects and raises the swing
  assign amp_above_high = line_out_pos_oe & tx_open;
  // broken pins trip the open and short detectors
  assign line_out_pos_fault = tx_short | tx_open;
  assign line_in_pos_fault = rx_open;
  // pulses show only when driven into an intact line
  assign line_out_pos_activity = line_out_pos_oe & ~tx_short & ~tx_open;
  // far end keeps sending coded marks unless its pin is open
  assign line_in_pos_activity = ~rx_open;
endmodule

//--- line_driver_ctrl_monitor_tb.sv
`timescale 1ns/1ps
`include "line_drv_defines.vh"

module line_driver_ctrl_monitor_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam N = 4;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1, s_axi_arvalid = 1'h0, s_axi_rready = 1'h1;
  logic [`ADDR_W-1:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ref_clk_in, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic proc_mode = 1'h0, hw_tx_output_enable = 1'h1, hw_tx_power_down = 1'h0;
  logic [N-1:0] tx_pos_data = 4'hF, tx_neg_data = 4'h0, tx_short = 4'h0, tx_open = 4'h0, rx_open = 4'h0;
  wire [N-1:0] amp_below_low, amp_above_high, line_out_pos_fault, line_in_pos_fault;
  wire [N-1:0] line_out_pos_activity, line_in_pos_activity, line_out_pos, line_out_pos_oe;
  wire [N-1:0] line_out_neg, line_out_neg_oe, tx_driver_power_on, tx_internal_term_on, rx_internal_term_on;
  wire [4*N-1:0] rx_term_value_adj_out;
  int n_fail = 0;
  int checked = 0;
  logic [31:0] rd;
  logic [1:0] rsp;

  // ----------------------------------------
  // design, line and clock
  // ----------------------------------------
  line_driver_ctrl_monitor #(.N_PORTS(N)) i_dut (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .proc_mode, .hw_tx_output_enable, .hw_tx_power_down,
    .ref_clk_in, .amp_below_low, .amp_above_high, .line_out_pos_fault, .line_in_pos_fault,
    .line_out_pos_activity, .line_in_pos_activity, .tx_pos_data, .tx_neg_data, .line_out_pos,
    .line_out_pos_oe, .line_out_neg, .line_out_neg_oe, .tx_driver_power_on, .tx_internal_term_on,
    .rx_internal_term_on, .rx_term_value_adj_out, .irq);
  coax_line_model #(.N_PORTS(N)) i_line (.line_out_pos_oe, .tx_short, .tx_open, .rx_open, .ref_clk_in,
    .amp_below_low, .amp_above_high, .line_out_pos_fault, .line_in_pos_fault, .line_out_pos_activity,
    .line_in_pos_activity);
  // 125 MHz core clock
  always #4 core_clk = ~core_clk;

  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge core_clk);
      if (s_axi_awready) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wready) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask
  // read one word
  task automatic axi_rd(input logic [`ADDR_W-1:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // verdict and end of run
  task automatic wrap_up;
    if (n_fail == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (6000) @(posedge core_clk);
    n_fail++;
    wrap_up;
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'h0;
    repeat (4) @(posedge core_clk);
    // reset values and unmapped place
    for (int i = 0; i < 5; i++) begin
      axi_rd(5'(i * 4));
      chk(rd, 32'h0);
    end
    chk(irq, 1'h0);
    axi_wr(5'h14, 32'hFFFF_FFFF);
    chk(rsp, `RESP_SLVERR);
    axi_rd(5'h14);
    chk(rd, 32'h0);
    chk(rsp, `RESP_SLVERR);
    // pin mode: registers kept but no termination
    axi_wr(`OFF_TERM, 32'hFFFF);
    axi_wr(`OFF_ADJ, 32'hFFFF);
    axi_rd(`OFF_TERM);
    chk(rd, 32'h0F0F);
    repeat (6) @(posedge core_clk);
    chk({tx_internal_term_on, rx_internal_term_on, rx_term_value_adj_out}, 24'h0);
    chk({line_out_pos_oe, line_out_neg_oe, tx_driver_power_on}, 12'hFFF);
    hw_tx_power_down <= 1'h1;
    repeat (6) @(posedge core_clk);
    chk({line_out_pos_oe, line_out_neg_oe, tx_driver_power_on}, 12'h000);
    hw_tx_power_down <= 1'h0;
    hw_tx_output_enable <= 1'h0;
    repeat (6) @(posedge core_clk);
    chk({line_out_pos_oe, line_out_neg_oe, tx_driver_power_on}, 12'h00F);
    // register mode: per-port enable, power-down and termination
    proc_mode <= 1'h1;
    tx_neg_data <= 4'h6;
    axi_wr(`OFF_CTRL, 32'h0405);
    axi_wr(`OFF_TERM, 32'h0A05);
    axi_wr(`OFF_ADJ, 32'hC3A5);
    repeat (6) @(posedge core_clk);
    chk({line_out_pos_oe, tx_driver_power_on, line_out_pos, line_out_neg}, 16'h1B10);
    chk({tx_internal_term_on, rx_internal_term_on, rx_term_value_adj_out}, 24'h5AC3A5);
    // amplitude monitor and failure alarm, port 1 powered down
    axi_wr(`OFF_CTRL, 32'h020F);
    tx_short <= 4'h3;
    tx_open <= 4'h4;
    repeat (200) @(posedge core_clk);
    axi_rd(`OFF_STATUS);
    chk(rd, 32'h0007_0700);
    repeat (200) @(posedge core_clk);
    axi_rd(`OFF_STATUS);
    chk(rd, 32'h0007_0705);
    chk(irq, 1'h0);
    axi_wr(`OFF_IRQ_EN, 32'h1);
    repeat (3) @(posedge core_clk);
    chk(irq, 1'h1);
    axi_wr(`OFF_STATUS, 32'h5);
    repeat (3) @(posedge core_clk);
    chk(irq, 1'h0);
    axi_wr(`OFF_IRQ_EN, 32'h100);
    repeat (3) @(posedge core_clk);
    chk(irq, 1'h1);
    axi_wr(`OFF_STATUS, 32'h700);
    repeat (3) @(posedge core_clk);
    chk(irq, 1'h0);
    // repair: ports with activity clear, idle port 1 keeps its alarm
    tx_short <= 4'h0;
    tx_open <= 4'h0;
    repeat (20) @(posedge core_clk);
    axi_rd(`OFF_STATUS);
    chk(rd, 32'h0002_0500);
    chk(irq, 1'h1);
    rx_open <= 4'h8;
    repeat (20) @(posedge core_clk);
    axi_rd(`OFF_STATUS);
    chk(rd, 32'h000A_0D00);
    wrap_up;
  end
endmodule
